// ---- hw/dual_dac_enable_control.sv ----
// two-channel dac enable control with apb register slave
//
// Overview of operation
// R01: control bits 4..0 read one, ignore writes
// R02: joint off: each channel follows own enable
// R03: all enables zero: no conversion anywhere
// R04: joint on: both channels always convert
// R05: bit 7 drives ch1, bit 6 ch0
// R06: output appears only after conversion time
// R07: value held until data rewrite or disable
// R08: data write restarts conversion immediately
// R09: level equals data over 256 times vref
// R10: clearing enable disables channel output
// R11: reset holds module stop, blocks registers
// R12: standby keeps present outputs unchanged
// R13: 8-bit data registers, reset zero, converted
// R14: per-channel cycle counter raises output valid
`timescale 1ns/100ps
`include "dac_ctrl_cfg.svh"

module dual_dac_enable_control (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// power mode pin
	input  wire logic        standby_req,
	// converter side
	output logic [1:0]       convert_en,
	output logic [1:0]       analog_oe,
	output logic [1:0]       out_valid,
	output logic [7:0]       analog_out_ch0,
	output logic [7:0]       analog_out_ch1
);

	logic [7:0]  ctl_q;
	logic [7:0]  ch0_data_reg_q;
	logic [7:0]  ch1_data_reg_q;
	logic        stop_q;
	dac_ctrl_pkg::count_t conv_cycles_q;
	logic        stby_s1_q;
	logic        stby_q;
	logic        wr_acc;
	logic        rd_acc;
	logic        data_ok;
	logic [1:0]  conv_d;
	logic [1:0]  data_wr;
	logic [1:0]  oe_bits;
	logic [31:0] rd_d;
	logic        err_d;
	dac_ctrl_pkg::sample_t data_ch [2];
	dac_ctrl_pkg::sample_t held_q [2];

	// standby pin comes from another domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stby_s1_q <= 1'b0;
			stby_q    <= 1'b0;
		end else begin
			stby_s1_q <= standby_req;
			stby_q    <= stby_s1_q;
		end
	end

	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	// only the stop register is reachable during module stop
	assign data_ok = !stop_q || (paddr == `OFF_STOP); // [R11]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_q <= `STOP_RESET; // [R11]
		end else if (wr_acc && paddr == `OFF_STOP && pstrb[0]) begin
			stop_q <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= `CTL_RSVD_MASK;
		end else if (wr_acc && data_ok && paddr == `OFF_CONTROL && pstrb[0]) begin
			ctl_q <= (pwdata[7:0] & `CTL_WR_MASK) | `CTL_RSVD_MASK; // [R01]
		end
	end

	assign data_wr[0] = wr_acc && data_ok && paddr == `OFF_CH0_DATA
		&& pstrb[0];
	assign data_wr[1] = wr_acc && data_ok && paddr == `OFF_CH1_DATA
		&& pstrb[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch0_data_reg_q <= `DATA_RESET; // [R13]
			ch1_data_reg_q <= `DATA_RESET;
		end else begin
			if (data_wr[0])
				ch0_data_reg_q <= pwdata[7:0];
			if (data_wr[1])
				ch1_data_reg_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_cycles_q <= `CONV_CYCLES_RESET;
		end else if (wr_acc && data_ok && paddr == `OFF_CONV_CYCLES) begin
			if (pstrb[0])
				conv_cycles_q[7:0] <= pwdata[7:0];
			if (pstrb[1])
				conv_cycles_q[15:8] <= pwdata[15:8];
		end
	end

	assign oe_bits[0] = ctl_q[`CTL_CH0_OE_BIT];
	assign oe_bits[1] = ctl_q[`CTL_CH1_OE_BIT];
	// joint enable forces conversion on, else per channel
	assign conv_d = ctl_q[`CTL_JOINT_BIT] ? 2'h3 : oe_bits; // [R02] [R03] [R04]
	assign data_ch[0] = ch0_data_reg_q;
	assign data_ch[1] = ch1_data_reg_q;

	// read mux and error answer
	always_comb begin
		rd_d  = 32'h0000_0000;
		err_d = 1'b0;
		if (!data_ok) begin
			err_d = 1'b1;
		end else begin
			case (paddr)
				`OFF_CH0_DATA:    rd_d[7:0]  = ch0_data_reg_q;
				`OFF_CH1_DATA:    rd_d[7:0]  = ch1_data_reg_q;
				`OFF_CONTROL:     rd_d[7:0]  = ctl_q; // [R01]
				`OFF_STOP:        rd_d[0]    = stop_q;
				`OFF_STATUS:      rd_d[3:0]  = {out_valid, convert_en};
				`OFF_CONV_CYCLES: rd_d[15:0] = conv_cycles_q;
				default:          err_d      = 1'b1;
			endcase
		end
	end

	// zero wait state slave: ready in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && err_d;
			if (psel && !penable && !pwrite)
				prdata <= rd_d;
		end
	end

	// standby freezes the enables so outputs are retained
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			convert_en <= 2'h0;
			analog_oe  <= 2'h0;
		end else if (!stby_q) begin // [R12]
			convert_en <= conv_d;
			analog_oe  <= oe_bits; // [R05] [R10]
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			dac_ctrl_pkg::ch_state_t st_q;
			dac_ctrl_pkg::count_t    cnt_q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					st_q      <= dac_ctrl_pkg::CH_IDLE;
					cnt_q     <= 16'h0000;
					held_q[g] <= 8'h00;
				end else if (!stby_q) begin // [R12]
					case (st_q)
						dac_ctrl_pkg::CH_IDLE: begin
							if (oe_bits[g]) begin // [R06]
								st_q  <= dac_ctrl_pkg::CH_CONV;
								cnt_q <= conv_cycles_q;
							end
						end
						dac_ctrl_pkg::CH_CONV: begin
							if (!oe_bits[g]) begin
								st_q <= dac_ctrl_pkg::CH_IDLE; // [R10]
							end else if (data_wr[g]) begin
								cnt_q <= conv_cycles_q; // [R08]
							end else if (cnt_q <= 16'h0001) begin
								st_q      <= dac_ctrl_pkg::CH_VALID; // [R14]
								held_q[g] <= data_ch[g]; // [R09] [R13]
							end else begin
								cnt_q <= cnt_q - 16'h0001;
							end
						end
						dac_ctrl_pkg::CH_VALID: begin
							if (!oe_bits[g]) begin
								st_q <= dac_ctrl_pkg::CH_IDLE; // [R10]
							end else if (data_wr[g]) begin // [R07] [R08]
								st_q  <= dac_ctrl_pkg::CH_CONV;
								cnt_q <= conv_cycles_q;
							end
						end
						default: st_q <= dac_ctrl_pkg::CH_IDLE;
					endcase
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					out_valid[g] <= 1'b0;
				else if (!stby_q)
					out_valid[g] <= (st_q == dac_ctrl_pkg::CH_VALID)
						&& oe_bits[g] && !data_wr[g];
			end
		end
	endgenerate

	// held code is the level in steps of vref/256
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_out_ch0 <= 8'h00;
			analog_out_ch1 <= 8'h00;
		end else begin
			analog_out_ch0 <= held_q[0]; // [R09]
			analog_out_ch1 <= held_q[1];
		end
	end

	joint_conv_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl_q[`CTL_JOINT_BIT] && !stby_q) |=> convert_en == 2'h3) // [R04]
		else $error("joint enable did not convert both");
	indep_conv_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctl_q[`CTL_JOINT_BIT] && !stby_q) |=> convert_en == $past(oe_bits)) // [R02]
		else $error("channel conversion not independent");
	all_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl_q[7:5] == 3'h0 && !stby_q) |=> convert_en == 2'h0) // [R03]
		else $error("conversion active with all enables clear");
	oe_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		!stby_q |=> analog_oe == $past(oe_bits)) // [R05]
		else $error("output enable does not follow bits");
	rsvd_ones_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctl_q[4:0] == 5'h1F) // [R01]
		else $error("reserved control bits not one");
	no_early_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(g_ch[0].st_q == dac_ctrl_pkg::CH_CONV) |=>
		!out_valid[0] [*2]) // [R06]
		else $error("channel 0 valid before conversion time");
	clear_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!oe_bits[0] && !stby_q) |=> ##1 !out_valid[0]) // [R10]
		else $error("channel 0 valid after disable");
	restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		(data_wr[1] && !stby_q) |=> !out_valid[1]) // [R08]
		else $error("channel 1 valid through data rewrite");
	hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(out_valid[0] && oe_bits[0] && !data_wr[0] && !stby_q) |=>
		$stable(held_q[0])) // [R07]
		else $error("channel 0 held value changed");
	stop_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(stop_q && wr_acc && paddr == `OFF_CONTROL) |=> $stable(ctl_q)) // [R11]
		else $error("control written during module stop");
	stby_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		stby_q |=> $stable(analog_oe) && $stable(convert_en)) // [R12]
		else $error("outputs changed in standby");

	// data registers take lane 0 and keep it otherwise
	data0_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		data_wr[0] |=> ch0_data_reg_q == $past(pwdata[7:0])) // [R13]
		else $error("channel 0 data write lost");
	data1_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		data_wr[1] |=> ch1_data_reg_q == $past(pwdata[7:0])) // [R13]
		else $error("channel 1 data write lost");
	data0_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		!data_wr[0] |=> $stable(ch0_data_reg_q)) // [R13]
		else $error("channel 0 data changed without write");
	data1_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		!data_wr[1] |=> $stable(ch1_data_reg_q)) // [R13]
		else $error("channel 1 data changed without write");

	// module stop answers every other address with an error
	stop_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && stop_q && paddr != `OFF_STOP) |=> pslverr) // [R11]
		else $error("no error answer during module stop");
	stop_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && stop_q && paddr != `OFF_STOP)
		|=> prdata == 32'h0000_0000) // [R11]
		else $error("read data leaked during module stop");
	stop_data_a: assert property (@(posedge pclk) disable iff (!presetn)
		(stop_q && wr_acc && paddr == `OFF_CH0_DATA) |=> // [R11]
		$stable(ch0_data_reg_q))
		else $error("data written during module stop");

	// control register write and read back
	ctl_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && !stop_q && paddr == `OFF_CONTROL)
		|=> prdata[4:0] == 5'h1F) // [R01]
		else $error("reserved bits not read as one");
	ctl_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && !stop_q && paddr == `OFF_CONTROL && pstrb[0]) |=> // [R05]
		ctl_q[7:5] == $past(pwdata[7:5]))
		else $error("control enable bits not written");

	// timing checks mirrored onto the other channel, plus a channel 1 valid-state check
	no_early1_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(g_ch[1].st_q == dac_ctrl_pkg::CH_CONV) |=> // [R06]
		!out_valid[1] [*2])
		else $error("channel 1 valid before conversion time");
	restart0_a: assert property (@(posedge pclk) disable iff (!presetn)
		(data_wr[0] && !stby_q) |=> !out_valid[0]) // [R08]
		else $error("channel 0 valid through data rewrite");
	clear_off1_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!oe_bits[1] && !stby_q) |=> ##1 !out_valid[1]) // [R10]
		else $error("channel 1 valid after disable");
	hold1_a: assert property (@(posedge pclk) disable iff (!presetn)
		(out_valid[1] && oe_bits[1] && !data_wr[1] && !stby_q) |=> // [R07]
		$stable(held_q[1]))
		else $error("channel 1 held value changed");
	idle_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
		(g_ch[1].st_q != dac_ctrl_pkg::CH_VALID && !stby_q) |=> // [R14]
		!out_valid[1])
		else $error("channel 1 valid without finished count");

	// presented code matches the held result when valid rises
	value0_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(out_valid[0]) |-> analog_out_ch0 == held_q[0]) // [R09]
		else $error("channel 0 output code wrong");
	value1_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(out_valid[1]) |-> analog_out_ch1 == held_q[1]) // [R09]
		else $error("channel 1 output code wrong");

	// standby keeps results and valid flags
	stby_held_a: assert property (@(posedge pclk) disable iff (!presetn)
		stby_q |=> $stable(held_q[0]) && $stable(held_q[1])) // [R12]
		else $error("held results changed in standby");
	stby_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
		stby_q |=> $stable(out_valid)) // [R12]
		else $error("valid flags changed in standby");

	conv_done_c: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(out_valid[0]));
	joint_c: cover property (@(posedge pclk) disable iff (!presetn)
		ctl_q[`CTL_JOINT_BIT] && !oe_bits[1] && convert_en[1]);
	rewrite_c: cover property (@(posedge pclk) disable iff (!presetn)
		out_valid[1] ##1 data_wr[1]);
	stby_c: cover property (@(posedge pclk) disable iff (!presetn)
		stby_q && out_valid[0]);
	stop_err_c: cover property (@(posedge pclk) disable iff (!presetn)
		pslverr && stop_q);

endmodule : dual_dac_enable_control

// ---- hw/dac_ctrl_cfg.svh ----
// offsets, field positions, reset values and timing counts of the dac control
`ifndef DAC_CTRL_CFG_SVH
`define DAC_CTRL_CFG_SVH
`define OFF_CH0_DATA      12'h000
`define OFF_CH1_DATA      12'h004
`define OFF_CONTROL       12'h008
`define OFF_STOP          12'h00C
`define OFF_STATUS        12'h010
`define OFF_CONV_CYCLES   12'h014
`define CTL_CH1_OE_BIT    7
`define CTL_CH0_OE_BIT    6
`define CTL_JOINT_BIT     5
`define CTL_RSVD_MASK     8'h1F
`define CTL_WR_MASK       8'hE0
`define DATA_RESET        8'h00
`define STOP_RESET        1'h1
`define CONV_TIME_NS      10000
`define CLK_PERIOD_NS     100
`define CONV_CYCLES_RESET 16'h0064
`endif

// ---- hw/dac_ctrl_pkg.sv ----
// types shared by the dac control
package dac_ctrl_pkg;
	typedef logic [7:0]  sample_t;
	typedef logic [15:0] count_t;
	typedef enum logic [1:0] {
		CH_IDLE,
		CH_CONV,
		CH_VALID
	} ch_state_t;
endpackage : dac_ctrl_pkg

// ---- bench/tb_dual_dac_enable_control.sv ----
// register and converter-control testbench for the dual dac enable control
`timescale 1ns/100ps
`include "dac_ctrl_cfg.svh"

module tb_dual_dac_enable_control;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        standby_req;
	logic [1:0]  convert_en;
	logic [1:0]  analog_oe;
	logic [1:0]  out_valid;
	logic [7:0]  analog_out_ch0;
	logic [7:0]  analog_out_ch1;
	logic [31:0] rd_d;
	logic        rd_e;
	int          bad_count;
	int          n_checks;

	dual_dac_enable_control u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.standby_req(standby_req), .convert_en(convert_en),
		.analog_oe(analog_oe), .out_valid(out_valid),
		.analog_out_ch0(analog_out_ch0), .analog_out_ch1(analog_out_ch1)
	);

	always #50 pclk = ~pclk;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// one apb transfer; waits for pready, no fixed latency assumed
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_d = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task cycles(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cycles

	task wait_valid(input int ch);
		int k;
		k = 0;
		while (out_valid[ch] !== 1'b1 && k < 20) begin
			cycles(1);
			k++;
		end
		check({31'h0, out_valid[ch]}, 32'h1);
	endtask : wait_valid

	initial begin
		#1000000;
		bad_count++;
		tally_and_finish;
	end

	initial begin
		pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF;
		standby_req = 1'b0; bad_count = 0; n_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFF_CONTROL, 32'h0);
		check({31'h0, rd_e}, 32'h1);
		check(rd_d, 32'h0);
		apb(1'b1, `OFF_CONTROL, 32'hE0);
		check({31'h0, rd_e}, 32'h1);
		apb(1'b1, `OFF_STOP, 32'h0);
		apb(1'b0, `OFF_CONTROL, 32'h0);
		check(rd_d, 32'h0000001F);
		apb(1'b0, `OFF_CH1_DATA, 32'h0);
		check(rd_d, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		check({31'h0, rd_e}, 32'h1);
		$display("test reset and access done");
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, `OFF_CONTROL, {24'h0, m[2:0], 5'h00});
			apb(1'b0, `OFF_CONTROL, 32'h0);
			check(rd_d, {24'h0, m[2:0], 5'h1F});
			cycles(2);
			check({30'h0, convert_en}, m[0] ? 32'h3 : {30'h0, m[2:1]});
			check({30'h0, analog_oe}, {30'h0, m[2:1]});
		end
		$display("test control modes done");
		apb(1'b1, `OFF_CONTROL, 32'h0);
		apb(1'b1, `OFF_CONV_CYCLES, 32'h3);
		apb(1'b1, `OFF_CH0_DATA, 32'h5A);
		apb(1'b0, `OFF_CH0_DATA, 32'h0);
		check(rd_d, 32'h5A);
		apb(1'b1, `OFF_CONTROL, 32'h40);
		cycles(1);
		check({31'h0, out_valid[0]}, 32'h0);
		wait_valid(0);
		check({24'h0, analog_out_ch0}, 32'h5A);
		cycles(10);
		check({30'h0, out_valid}, 32'h1);
		check({24'h0, analog_out_ch0}, 32'h5A);
		apb(1'b1, `OFF_CH0_DATA, 32'hA5);
		cycles(2);
		check({31'h0, out_valid[0]}, 32'h0);
		wait_valid(0);
		check({24'h0, analog_out_ch0}, 32'hA5);
		$display("test channel 0 conversion done");
		apb(1'b1, `OFF_CH1_DATA, 32'hC3);
		apb(1'b1, `OFF_CONTROL, 32'hA0);
		cycles(3);
		check({31'h0, out_valid[0]}, 32'h0);
		check({30'h0, analog_oe}, 32'h2);
		wait_valid(1);
		check({24'h0, analog_out_ch1}, 32'hC3);
		apb(1'b0, `OFF_STATUS, 32'h0);
		check(rd_d, 32'hB);
		standby_req <= 1'b1;
		cycles(14);
		check({30'h0, out_valid}, 32'h2);
		check({30'h0, convert_en}, 32'h3);
		check({24'h0, analog_out_ch1}, 32'hC3);
		standby_req <= 1'b0;
		$display("test channel 1 and standby done");
		@(posedge pclk);
		presetn <= 1'b0;
		cycles(2);
		check({18'h0, convert_en, analog_oe, out_valid, analog_out_ch1},
			32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFF_CH0_DATA, 32'h0);
		check({31'h0, rd_e}, 32'h1);
		check(rd_d, 32'h0);
		$display("test mid-run reset done");
		tally_and_finish;
	end
endmodule : tb_dual_dac_enable_control
